// ---- verilog/sdc_map.vh ----
`ifndef SDC_MAP_VH
`define SDC_MAP_VH

// =====================================================================
// register byte offsets
`define SDC_REG_DESC_LO   8'h00
`define SDC_REG_DESC_HI   8'h04
`define SDC_REG_OFFSET    8'h08
`define SDC_REG_CTRL      8'h0C
`define SDC_REG_STATUS    8'h10
`define SDC_REG_BASE      8'h14
`define SDC_REG_LIMIT     8'h18
`define SDC_REG_ATTR      8'h1C

// =====================================================================
// second doubleword field positions
`define SDC_HI_TOUCHED    8
`define SDC_HI_PERMIT     9
`define SDC_HI_DIRCONF    10
`define SDC_HI_CODE       11
`define SDC_HI_CLASS      12
`define SDC_HI_DPL_LO     13
`define SDC_HI_DPL_HI     14
`define SDC_HI_PRESENT    15
`define SDC_HI_LIM_LO     16
`define SDC_HI_LIM_HI     19
`define SDC_HI_WIDE       21
`define SDC_HI_DSIZE      22
`define SDC_HI_SCALE      23

// =====================================================================
// control bits
`define SDC_CTRL_LOAD     0
`define SDC_CTRL_STACK    1
`define SDC_CTRL_LONG     2
`define SDC_CTRL_MEMWR    3
`define SDC_CTRL_PFX_OP   4
`define SDC_CTRL_PFX_AD   5

// =====================================================================
// status bits
`define SDC_ST_LIMIT      0
`define SDC_ST_GP         1
`define SDC_ST_ABSENT     2
`define SDC_ST_LOADED     3

// =====================================================================
// reset values and bounds
`define SDC_RST_WORD      32'h0000_0000
`define SDC_BOUND_SMALL   32'h0000_FFFF
`define SDC_BOUND_BIG     32'hFFFF_FFFF
`define SDC_SCALE_FILL    12'hFFF

`endif

// ---- verilog/sdc_decode.v ----
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.vh"

module sdc_decode
(
    input  wire [31:0] desc_lo,      // first doubleword
    input  wire [31:0] desc_hi,      // second doubleword
    input  wire        long_mode,    // long mode active
    output wire [31:0] base,         // joined base address
    output wire [19:0] limit,        // joined raw limit
    output wire        scale,        // limit in 4 KByte units
    output wire        system,       // system descriptor
    output wire        code,         // code segment
    output wire        touched,      // accessed bit
    output wire        permit,       // write or read permit
    output wire        dir_conf,     // expand-down or conforming
    output wire [1:0]  segment_privilege_level,          // segment privilege level
    output wire        present,      // presence flag
    output wire        dsize,        // default size flag
    output wire        wide          // native 64-bit code
);

    // =================================================================
    // field extraction; bit 20 is left for system software
    assign limit    = {desc_hi[`SDC_HI_LIM_HI:`SDC_HI_LIM_LO],
                       desc_lo[15:0]};
    assign base     = {desc_hi[31:24], desc_hi[7:0],
                       desc_lo[31:16]};
    assign scale    = desc_hi[`SDC_HI_SCALE];
    assign system   = ~desc_hi[`SDC_HI_CLASS];
    assign code     = desc_hi[`SDC_HI_CLASS]
                    & desc_hi[`SDC_HI_CODE];
    assign touched  = desc_hi[`SDC_HI_TOUCHED];
    assign permit   = desc_hi[`SDC_HI_PERMIT];
    assign dir_conf = desc_hi[`SDC_HI_DIRCONF];
    assign segment_privilege_level      = desc_hi[`SDC_HI_DPL_HI:`SDC_HI_DPL_LO];
    assign present  = desc_hi[`SDC_HI_PRESENT];
    assign dsize    = desc_hi[`SDC_HI_DSIZE];
    // outside long mode or for data the bit is reserved and ignored
    assign wide     = long_mode & code & desc_hi[`SDC_HI_WIDE];

endmodule // sdc_decode

`default_nettype wire

// ---- verilog/sdc_limit_chk.v ----
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.vh"

module sdc_limit_chk
(
    input  wire [31:0] offset,       // offset under test
    input  wire [19:0] limit,        // raw 20-bit limit
    input  wire        scale,        // limit in 4 KByte units
    input  wire        expand_down,  // expand-down data segment
    input  wire        dsize,        // upper bound select
    output wire [31:0] byte_limit,   // scaled limit in bytes
    output wire        fault         // offset outside segment
);

    // =================================================================
    // purely combinational so a fault shows in the presenting cycle
    wire [31:0] upper;
    wire        above;
    wire        below;

    assign byte_limit = scale ? {limit, `SDC_SCALE_FILL}
                              : {12'h000, limit};
    // with scaling the low twelve offset bits take no part
    assign above = scale ? (offset[31:12] > limit)
                         : (offset > byte_limit);
    assign below = scale ? (offset[31:12] < limit)
                         : (offset < byte_limit);
    assign upper = dsize ? `SDC_BOUND_BIG : `SDC_BOUND_SMALL;
    assign fault = expand_down ? (below | (offset > upper))
                               : above;

endmodule // sdc_limit_chk

`default_nettype wire

// ---- verilog/sdc_top.v ----
// What this block does
// - join both limit parts into 20 bits
// - scale flag picks byte or 4 KByte units
// - scaled checks ignore low twelve offset bits
// - expand-up: offset above limit faults
// - expand-down: offset below limit faults
// - default size picks expand-down upper bound
// - join three base parts into 32 bits
// - class flag clear means system descriptor
// - type bit 11 selects code or data
// - data type bits: touched, write, direction
// - code type bits: touched, read, conforming
// - two-bit privilege level, zero most privileged
// - absent segment load raises absent fault
// - code default size picks 32/16 bit, prefixes override
// - stack default size picks stack pointer width
// - long mode wide flag selects 64-bit code
// - bit 20 ignored by hardware
// - load sets touched bit if memory writable
// - stack load of read-only data faults
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.vh"

module sdc_top
#(
    parameter AW = 8                 // apb address width
)
(
    input  wire          pclk,       // bus clock
    input  wire          presetn,    // async reset, low
    input  wire          psel,       // apb select
    input  wire          penable,    // apb enable
    input  wire          pwrite,     // apb direction
    input  wire [AW-1:0] paddr,      // apb byte address
    input  wire [31:0]   pwdata,     // apb write data
    output reg  [31:0]   prdata,     // apb read data
    output reg           pready,     // apb ready
    output reg           pslverr,    // apb error
    output reg           limit_fault_ff,  // offset check fault
    output reg           gp_fault_ff,     // sticky protection fault
    output reg           absent_fault_ff  // sticky absent fault
);

    // =================================================================
    // address decode, shared by read and write paths
    function mapped;
        input [AW-1:0] a;
        begin
            case (a[7:0])
                `SDC_REG_DESC_LO,
                `SDC_REG_DESC_HI,
                `SDC_REG_OFFSET,
                `SDC_REG_CTRL,
                `SDC_REG_STATUS,
                `SDC_REG_BASE,
                `SDC_REG_LIMIT,
                `SDC_REG_ATTR: mapped = 1'b1;
                default:       mapped = 1'b0;
            endcase
        end
    endfunction

    // =================================================================
    // state
    reg [31:0] desc_lo_ff;
    reg [31:0] desc_hi_ff;
    reg [31:0] offset_ff;
    reg [5:1]  ctrl_ff;
    reg [31:0] cache_lo_ff;
    reg [31:0] cache_hi_ff;
    reg        cache_stack_ff;
    reg        cache_valid_ff;
    reg        loaded_ff;

    reg [31:0] nxt_prdata;
    reg [31:0] nxt_desc_hi;
    reg        nxt_gp;
    reg        nxt_absent;
    reg        nxt_loaded;

    wire setup  = psel & ~penable;
    wire access = psel & penable & pready;
    wire wr_acc = access & pwrite & ~pslverr;
    wire ok_adr = mapped(paddr) & (paddr[1:0] == 2'b00);

    // =================================================================
    // live decode of the descriptor staged for a load
    wire [31:0] l_base;
    wire [19:0] l_limit;
    wire        l_scale;
    wire        l_system;
    wire        l_code;
    wire        l_touched;
    wire        l_permit;
    wire        l_dirconf;
    wire [1:0]  l_dpl;
    wire        l_present;
    wire        l_dsize;
    wire        l_wide;

    sdc_decode u_live
    (
        .desc_lo  (desc_lo_ff),
        .desc_hi  (desc_hi_ff),
        .long_mode(ctrl_ff[`SDC_CTRL_LONG]),
        .base     (l_base),
        .limit    (l_limit),
        .scale    (l_scale),
        .system   (l_system),
        .code     (l_code),
        .touched  (l_touched),
        .permit   (l_permit),
        .dir_conf (l_dirconf),
        .segment_privilege_level      (l_dpl),
        .present  (l_present),
        .dsize    (l_dsize),
        .wide     (l_wide)
    );

    // =================================================================
    // decode of the loaded (hidden) segment copy
    wire [31:0] c_base;
    wire [19:0] c_limit;
    wire        c_scale;
    wire        c_system;
    wire        c_code;
    wire        c_touched;
    wire        c_permit;
    wire        c_dirconf;
    wire [1:0]  c_dpl;
    wire        c_present;
    wire        c_dsize;
    wire        c_wide;

    sdc_decode u_cache
    (
        .desc_lo  (cache_lo_ff),
        .desc_hi  (cache_hi_ff),
        .long_mode(ctrl_ff[`SDC_CTRL_LONG]),
        .base     (c_base),
        .limit    (c_limit),
        .scale    (c_scale),
        .system   (c_system),
        .code     (c_code),
        .touched  (c_touched),
        .permit   (c_permit),
        .dir_conf (c_dirconf),
        .segment_privilege_level      (c_dpl),
        .present  (c_present),
        .dsize    (c_dsize),
        .wide     (c_wide)
    );

    // =================================================================
    // offset check against the loaded segment
    wire [31:0] byte_limit;
    wire        chk_fault;
    wire        c_expdown = ~c_system & ~c_code & c_dirconf;

    sdc_limit_chk u_chk
    (
        .offset     (offset_ff),
        .limit      (c_limit),
        .scale      (c_scale),
        .expand_down(c_expdown),
        .dsize      (c_dsize),
        .byte_limit (byte_limit),
        .fault      (chk_fault)
    );

    // =================================================================
    // operating size view of the loaded segment
    // wide code ignores the default size flag and both prefixes
    wire code32  = c_code & c_dsize & ~c_wide;
    wire addr32  = code32 ^ (c_code & ~c_wide
                 & ctrl_ff[`SDC_CTRL_PFX_AD]);
    wire op32    = code32 ^ (c_code & ~c_wide
                 & ctrl_ff[`SDC_CTRL_PFX_OP]);
    wire stack32 = cache_stack_ff & c_dsize;

    wire [31:0] attr = {18'h0_0000, c_scale, stack32, op32, addr32,
                        c_wide, c_dsize, c_dpl, c_present, c_dirconf,
                        c_permit, c_touched, c_code, c_system};

    wire [31:0] status = {28'h000_0000, loaded_ff, absent_fault_ff,
                          gp_fault_ff, limit_fault_ff};

    // =================================================================
    // segment load request
    wire load_req = wr_acc & (paddr[7:0] == `SDC_REG_CTRL)
                  & pwdata[`SDC_CTRL_LOAD];
    wire ld_stack = pwdata[`SDC_CTRL_STACK];
    wire ld_memwr = pwdata[`SDC_CTRL_MEMWR];
    // a stack needs a writable data segment
    wire ld_gp    = ld_stack & (l_system | l_code | ~l_permit);
    wire ld_ok    = load_req & l_present & ~ld_gp;
    wire st_clr   = wr_acc & (paddr[7:0] == `SDC_REG_STATUS);

    always @*
    begin
        nxt_desc_hi = desc_hi_ff;
        if (wr_acc && paddr[7:0] == `SDC_REG_DESC_HI)
            nxt_desc_hi = pwdata;
        // ro memory keeps its copy; setting it there would never stick
        if (ld_ok && ld_memwr)
            nxt_desc_hi[`SDC_HI_TOUCHED] = 1'b1;
    end

    // set wins over a write-one clear in the same cycle
    always @*
    begin
        nxt_absent = absent_fault_ff;
        nxt_gp     = gp_fault_ff;
        nxt_loaded = loaded_ff;
        if (st_clr)
        begin
            nxt_absent = absent_fault_ff & ~pwdata[`SDC_ST_ABSENT];
            nxt_gp     = gp_fault_ff & ~pwdata[`SDC_ST_GP];
            nxt_loaded = loaded_ff & ~pwdata[`SDC_ST_LOADED];
        end
        if (load_req && !l_present)
            nxt_absent = 1'b1;
        if (load_req && l_present && ld_gp)
            nxt_gp = 1'b1;
        if (ld_ok)
            nxt_loaded = 1'b1;
    end

    // =================================================================
    // read mux, evaluated in the setup cycle
    always @*
    begin
        case (paddr[7:0])
            `SDC_REG_DESC_LO: nxt_prdata = desc_lo_ff;
            `SDC_REG_DESC_HI: nxt_prdata = desc_hi_ff;
            `SDC_REG_OFFSET:  nxt_prdata = offset_ff;
            `SDC_REG_CTRL:    nxt_prdata = {26'h000_0000, ctrl_ff, 1'b0};
            `SDC_REG_STATUS:  nxt_prdata = status;
            `SDC_REG_BASE:    nxt_prdata = c_base;
            `SDC_REG_LIMIT:   nxt_prdata = byte_limit;
            `SDC_REG_ATTR:    nxt_prdata = attr;
            default:          nxt_prdata = `SDC_RST_WORD;
        endcase
    end

    // =================================================================
    // apb slave: one wait-free access cycle after setup
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= `SDC_RST_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~ok_adr;
            if (setup && !pwrite && ok_adr)
                prdata <= nxt_prdata;
            else if (setup)
                prdata <= `SDC_RST_WORD;
        end
    end

    // =================================================================
    // registers and hidden segment copy
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            desc_lo_ff      <= `SDC_RST_WORD;
            desc_hi_ff      <= `SDC_RST_WORD;
            offset_ff       <= `SDC_RST_WORD;
            ctrl_ff         <= 5'h00;
            cache_lo_ff     <= `SDC_RST_WORD;
            cache_hi_ff     <= `SDC_RST_WORD;
            cache_stack_ff  <= 1'b0;
            cache_valid_ff  <= 1'b0;
            loaded_ff       <= 1'b0;
            gp_fault_ff     <= 1'b0;
            absent_fault_ff <= 1'b0;
            limit_fault_ff  <= 1'b0;
        end
        else
        begin
            if (wr_acc && paddr[7:0] == `SDC_REG_DESC_LO)
                desc_lo_ff <= pwdata;
            if (wr_acc && paddr[7:0] == `SDC_REG_OFFSET)
                offset_ff <= pwdata;
            if (wr_acc && paddr[7:0] == `SDC_REG_CTRL)
                ctrl_ff <= pwdata[5:1];
            desc_hi_ff <= nxt_desc_hi;
            if (ld_ok)
            begin
                cache_lo_ff    <= desc_lo_ff;
                cache_hi_ff    <= nxt_desc_hi;
                cache_stack_ff <= ld_stack;
                cache_valid_ff <= 1'b1;
            end
            loaded_ff       <= nxt_loaded;
            gp_fault_ff     <= nxt_gp;
            absent_fault_ff <= nxt_absent;
            limit_fault_ff  <= chk_fault & cache_valid_ff;
        end
    end

endmodule // sdc_top

`default_nettype wire

// ---- test/sdc_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.vh"
// ==========
// bus and fault checks at the top ports
module sdc_props
#(
    parameter AW = 8                 // address width
)
(
    input wire logic          pclk,    // clock
    input wire logic          presetn, // reset, low
    input wire logic          psel,    // select
    input wire logic          penable, // enable
    input wire logic          pwrite,  // direction
    input wire logic [AW-1:0] paddr,   // address
    input wire logic [31:0]   pwdata,  // write data
    input wire logic [31:0]   prdata,  // read data
    input wire logic          pready,  // ready
    input wire logic          pslverr, // error
    input wire logic          limit_fault_ff,  // offset fault
    input wire logic          gp_fault_ff,     // protection
    input wire logic          absent_fault_ff  // absent
);
    wire acc = psel && penable && pready && pwrite;
    wire ld  = acc && paddr == `SDC_REG_CTRL && pwdata[`SDC_CTRL_LOAD];
    wire clr = acc && paddr == `SDC_REG_STATUS;
    wire upd = ld || (acc && paddr == `SDC_REG_OFFSET);
    wire bad = paddr > `SDC_REG_ATTR || paddr[1:0] != 2'b00;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_setup_answer: assert property (s_setup |=> s_answer)
        else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    a_err_nodata: assert property (pslverr |-> pready && prdata == 0)
        else $error("error without ready or with data");
    a_err_unmapped: assert property (s_setup ##0 bad |=> pslverr)
        else $error("bad address not refused");
    a_gp_sticky: assert property (
        gp_fault_ff && !(clr && pwdata[`SDC_ST_GP]) |=> gp_fault_ff)
        else $error("protection flag lost");
    a_absent_sticky: assert property (
        absent_fault_ff && !(clr && pwdata[`SDC_ST_ABSENT])
        |=> absent_fault_ff)
        else $error("absent flag lost");
    a_gp_cause: assert property (
        $rose(gp_fault_ff) |-> $past(ld && pwdata[`SDC_CTRL_STACK]))
        else $error("protection flag without stack load");
    a_absent_cause: assert property (
        $rose(absent_fault_ff) |-> $past(ld))
        else $error("absent flag without load");
    a_limit_cause: assert property (
        $changed(limit_fault_ff) |-> $past(upd, 2))
        else $error("offset fault moved without update");
endmodule // sdc_props
bind sdc_top sdc_props #(.AW(AW)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .limit_fault_ff(limit_fault_ff),
    .gp_fault_ff(gp_fault_ff), .absent_fault_ff(absent_fault_ff));
`default_nettype wire

// ---- test/sdc_apb_bfm.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// bus master standing in for the processor side
module sdc_apb_bfm
(
    input  wire logic        pclk,    // clock
    input  wire logic        pready,  // ready
    input  wire logic        pslverr, // error
    input  wire logic [31:0] prdata,  // read data
    output var  logic        psel,    // select
    output var  logic        penable, // enable
    output var  logic        pwrite,  // direction
    output var  logic [7:0]  paddr,   // address
    output var  logic [31:0] pwdata   // write data
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip so stale values cannot pass for good ones
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // sdc_apb_bfm
`default_nettype wire

// ---- test/sdc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.vh"
module sdc_top_tb;
    logic        pclk;
    logic        presetn;
    wire         psel, penable, pwrite, pready, pslverr, lim_f, gp_f, ab_f;
    wire  [7:0]  paddr;
    wire  [31:0] pwdata, prdata;
    logic [31:0] rd, lo, hi, ctl, off, eb, el, ea, eh, ldh, ldl;
    logic        err, ok, lds;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    sdc_apb_bfm u_bfm (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    sdc_top #(.AW(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .limit_fault_ff(lim_f), .gp_fault_ff(gp_f), .absent_fault_ff(ab_f));
    // ==========
    // expectations
    function automatic logic [31:0] f_blim(input logic [31:0] h, l);
        if (h[`SDC_HI_SCALE])
            return {h[19:16], l[15:0], 12'hFFF};
        return {12'h000, h[19:16], l[15:0]};
    endfunction
    function automatic logic f_fault(input logic [31:0] h, l, o);
        logic [19:0] lim;
        lim = {h[19:16], l[15:0]};
        if (h[`SDC_HI_CODE] || !h[`SDC_HI_DIRCONF])
            return o > f_blim(h, l);
        return (h[`SDC_HI_SCALE] ? o[31:12] < lim : o < {12'h000, lim})
            || o > (h[`SDC_HI_DSIZE] ? 32'hFFFF_FFFF : 32'h0000_FFFF);
    endfunction
    function automatic logic [31:0] f_attr(input logic [31:0] h, c);
        logic cd, wd;
        // wide code only in long mode; it ignores size flag and prefixes
        wd = c[2] & h[12] & h[11] & h[21];
        cd = h[12] & h[11] & !wd;
        return {18'h0_0000, h[23], c[1] & h[22], cd & (h[22] ^ c[4]),
            cd & (h[22] ^ c[5]), wd, h[22], h[14:13], h[15], h[10],
            h[9], h[8], h[12] & h[11], !h[12]};
    endfunction
    // ==========
    // bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_bfm.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, m);
        u_bfm.xfer(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd & m, e & m);
    endtask
    task automatic chk_off(input logic [31:0] o);
        wr(`SDC_REG_OFFSET, o);
        // fault register trails the offset register by one edge
        repeat (2) @(posedge pclk);
        chk(lim_f, f_fault(ldh, ldl, o));
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop;
        end
    end
    // ==========
    // main sequence
    initial
    begin
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd = $urandom(32'he17e);
        // an all-zero hidden copy decodes as a system descriptor
        for (int a = 0; a < 32; a += 4)
            rdc(a[7:0], (a == `SDC_REG_ATTR) ? f_attr(32'h0000_0000,
                32'h0000_0000) : 32'h0000_0000, 32'hFFFF_FFFF);
        $display("test reset_values done");
        u_bfm.xfer(1'b0, 8'h20, 32'h0000_0000, rd, err);
        chk({rd[30:0], err}, 32'h0000_0001);
        u_bfm.xfer(1'b1, 8'h06, 32'h0000_0001, rd, err);
        chk(err, 1'b1);
        $display("test refusals done");
        for (int i = 0; i < 60; i++)
        begin
            lo = $urandom;
            hi = $urandom;
            ctl = $urandom & 32'h0000_003E;
            hi[`SDC_HI_PRESENT] = ($urandom % 8) != 0;
            ctl[1] = ctl[1] & hi[`SDC_HI_PRESENT];
            hi[`SDC_HI_CLASS] = hi[`SDC_HI_CLASS] | !ctl[1];
            hi[21] = hi[21] & ctl[2] & hi[11];
            hi[22] = hi[22] & !hi[21];
            if (i == 0)
            begin
                lo[15:0] = 16'h0000;
                hi = 32'h0080_9200;
                ctl = 32'h0000_0000;
            end
            wr(`SDC_REG_CTRL, ctl);
            wr(`SDC_REG_DESC_LO, lo);
            wr(`SDC_REG_DESC_HI, hi);
            wr(`SDC_REG_CTRL, ctl | 32'h0000_0001);
            ok = hi[15] && !(ctl[1] && (!hi[12] || hi[11] || !hi[9]));
            eh = hi;
            if (ok)
            begin
                eh[8] = hi[8] | ctl[3];
                ldh = eh;
                ldl = lo;
                lds = ctl[1];
                eb = {hi[31:24], hi[7:0], lo[31:16]};
                el = f_blim(hi, lo);
            end
            // the hidden copy keeps its stack flag; long mode and
            // prefixes come live from the control register
            ea = f_attr(ldh, {ctl[31:2], lds, 1'b0});
            rdc(`SDC_REG_STATUS, {ok, !hi[15], hi[15] & !ok, 1'b0} << 0,
                32'h0000_000E);
            chk({ab_f, gp_f}, {!hi[15], hi[15] & !ok});
            wr(`SDC_REG_STATUS, 32'h0000_000E);
            rdc(`SDC_REG_STATUS, 32'h0000_0000, 32'h0000_000E);
            chk({ab_f, gp_f}, 2'b00);
            wr(`SDC_REG_BASE, $urandom);
            rdc(`SDC_REG_BASE, eb, 32'hFFFF_FFFF);
            rdc(`SDC_REG_LIMIT, el, 32'hFFFF_FFFF);
            rdc(`SDC_REG_DESC_HI, eh, 32'hFFFF_FFFF);
            rdc(`SDC_REG_ATTR, ea, 32'h0000_00FF);
            chk(rd & 32'h0000_00FF, ea & 32'h0000_00FF);
            chk(rd & 32'hFFFF_FD00, ea & 32'hFFFF_FD00);
            chk(rd & 32'h0000_0200, ea & 32'h0000_0200);
            for (int k = 0; k < 5; k++)
            begin
                case (k)
                    0: off = $urandom;
                    1: off = el;
                    2: off = el + 32'h0000_0001;
                    3: off = el - 32'h0000_0001;
                    default: off = {ldh[19:16], ldl[15:0], 12'h000} - 1;
                endcase
                chk_off(off);
            end
        end
        $display("test descriptor_loads done");
        report_and_stop;
    end
endmodule // sdc_top_tb
`default_nettype wire
